// ### logic/rusp_defs.svh
// Constants of the remote upgrade shift port
`ifndef RUSP_DEFS_SVH
`define RUSP_DEFS_SVH

// Register widths
`define RUSP_STATUS_W       5
`define RUSP_CONTROL_W      22

// Reset values
`define RUSP_STATUS_RST     5'h0_0
`define RUSP_CONTROL_RST    22'h00_0000
`define RUSP_UPDATE_RST     22'h00_0000

// Watchdog field: top 12 bits of control, each step 2**17 ticks
`define RUSP_WD_FIELD_W     12
`define RUSP_WD_FIELD_LSB   10
`define RUSP_WD_GRAN_SHIFT  17
`define RUSP_WD_COUNT_W     29

// Status buffer
`define RUSP_FIFO_DEPTH     8

`endif

// ### logic/rusp_pkg.sv
// Types shared by the remote upgrade shift port
package rusp_pkg;

  // Which image is currently running
  typedef enum logic
  {
    RUSP_FACTORY,
    RUSP_APPLICATION
  } rusp_mode_type;

  // Action selected by the two select lines on a shift clock edge
  typedef enum logic [1:0]
  {
    RUSP_ACT_SHIFT,
    RUSP_ACT_CAPTURE,
    RUSP_ACT_UPDATE
  } rusp_act_type;

endpackage

// ### logic/rusp_port.sv
// Remote upgrade shift port with its status buffer FIFO
`include "rusp_defs.svh"

// Small flip-flop FIFO with valid and ready on both sides
module rusp_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input  wire logic             clock,
  input  wire logic             clock_enable,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } rusp_fifo_state_type;

  rusp_fifo_state_type state_reg;
  rusp_fifo_state_type state_next;
  logic                push;
  logic                pop;

  // Advance a pointer with wrap at the depth
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] ptr);
    if (ptr == AW'(DEPTH - 1))
      bump = '0;
    else
      bump = ptr + AW'(1);
  endfunction

  // Full and empty flags; nothing is taken while the state is frozen
  assign in_ready  = clock_enable && (state_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (state_reg.count != '0);
  assign out_data  = state_reg.mem[state_reg.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next state of storage and pointers
  always_comb
  begin
    state_next = state_reg;
    if (push)
    begin
      state_next.mem[state_reg.wr_ptr] = in_data;
      state_next.wr_ptr = bump(state_reg.wr_ptr);
    end
    if (pop)
      state_next.rd_ptr = bump(state_reg.rd_ptr);
    if (push && !pop)
      state_next.count = state_reg.count + (AW+1)'(1);
    else if (pop && !push)
      state_next.count = state_reg.count - (AW+1)'(1);
  end

  // State register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '0;
    else if (clock_enable)
      state_reg <= state_next;
  end
endmodule

// Operation
// - Shift select high shifts register left per edge
// - Both selects low copy shift into update, in the factory image only
// - Capture loads status plus control or update
// - Capture select ignored while shift select high
// - Serial input enters shift register each shift edge
// - Serial output shows new bit per shift or capture edge
// - Shift and update registers act only on shift clock rising
// - Watchdog reload falling edge reloads timer in the application image
// - Reconfig request low starts other image load
// - Request release copies update into control
module rusp_port
#(
  parameter int STATUS_W   = `RUSP_STATUS_W,
  parameter int CONTROL_W  = `RUSP_CONTROL_W,
  parameter int FIFO_DEPTH = `RUSP_FIFO_DEPTH,
  parameter int WD_GRAN    = `RUSP_WD_GRAN_SHIFT
)
(
  input  wire logic                 clock,
  input  wire logic                 clock_enable,
  input  wire logic                 reset_n,
  input  wire logic                 upgrade_shift_clock,
  input  wire logic                 shift_or_load_select,
  input  wire logic                 capture_or_update_select,
  input  wire logic                 upgrade_serial_in,
  output logic                      upgrade_serial_out,
  input  wire logic                 watchdog_reload_n,
  input  wire logic                 reconfig_request_n,
  input  wire logic                 watchdog_tick,
  input  wire logic                 status_valid,
  output logic                      status_ready,
  input  wire logic [STATUS_W-1:0]  status_data,
  output logic                      reconfig_start,
  output logic                      reconfig_to_factory,
  output logic                      running_factory,
  output logic [CONTROL_W-1:0]      control_word,
  output logic                      watchdog_expired
);
  localparam int SR_W = STATUS_W + CONTROL_W;
  localparam int WC_W = `RUSP_WD_COUNT_W;

  typedef struct packed
  {
    logic [SR_W-1:0]       shift;
    logic [CONTROL_W-1:0]  update;
    logic [CONTROL_W-1:0]  control;
    logic [STATUS_W-1:0]   status;
    rusp_pkg::rusp_mode_type mode;
    logic                  sclk_prev;
    logic                  wd_prev;
    logic                  cfg_prev;
    logic [WC_W-1:0]       wd_count;
    logic                  start;
    logic                  to_factory;
    logic                  expired;
  } rusp_state_type;

  rusp_state_type        state_reg;
  rusp_state_type        state_next;
  logic [1:0]            rst_sync_reg;
  logic                  rst_n;
  logic                  sclk_rise;
  rusp_pkg::rusp_act_type act;
  logic                  fifo_valid;
  logic                  fifo_pop;
  logic [STATUS_W-1:0]   fifo_data;

  // Initial watchdog count from the control word's top field
  function automatic logic [WC_W-1:0] wd_initial(
    input logic [CONTROL_W-1:0] ctl
  );
    logic [`RUSP_WD_FIELD_W-1:0] field;
    field = ctl[`RUSP_WD_FIELD_LSB +: `RUSP_WD_FIELD_W];
    wd_initial = WC_W'({field, {WD_GRAN{1'b0}}});
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Rising edge of the fabric-driven shift clock
  assign sclk_rise = clock_enable && upgrade_shift_clock
                     && !state_reg.sclk_prev;

  // Select decode; capture line only matters with shift low
  always_comb
  begin
    if (shift_or_load_select)
      act = rusp_pkg::RUSP_ACT_SHIFT;
    else if (capture_or_update_select)
      act = rusp_pkg::RUSP_ACT_CAPTURE;
    else
      act = rusp_pkg::RUSP_ACT_UPDATE;
  end

  // Fresh status is taken from the buffer on each capture that finds it non-empty
  assign fifo_pop = sclk_rise && (act == rusp_pkg::RUSP_ACT_CAPTURE);

  rusp_fifo
  #(
    .WIDTH (STATUS_W),
    .DEPTH (FIFO_DEPTH)
  )
  u_status_fifo
  (
    .clock        (clock),
    .clock_enable (clock_enable),
    .rst_n        (rst_n),
    .in_valid     (status_valid),
    .in_ready     (status_ready),
    .in_data      (status_data),
    .out_valid    (fifo_valid),
    .out_ready    (fifo_pop),
    .out_data     (fifo_data)
  );

  // Next state of the whole port
  always_comb
  begin
    logic [STATUS_W-1:0]  cap_status;
    logic [CONTROL_W-1:0] cap_word;
    logic                 wd_fire;
    wd_fire    = 1'b0;
    cap_status = fifo_valid ? fifo_data : state_reg.status;
    cap_word   = (state_reg.mode == rusp_pkg::RUSP_FACTORY)
                 ? state_reg.update : state_reg.control;
    state_next = state_reg;
    state_next.sclk_prev = upgrade_shift_clock;
    state_next.wd_prev   = watchdog_reload_n;
    state_next.cfg_prev  = reconfig_request_n;
    state_next.start     = 1'b0;

    // Shift register and update register on shift clock edges
    if (sclk_rise)
    begin
      case (act)
        rusp_pkg::RUSP_ACT_SHIFT:
          state_next.shift = {state_reg.shift[SR_W-2:0],
                              upgrade_serial_in};
        rusp_pkg::RUSP_ACT_CAPTURE:
        begin
          state_next.status = cap_status;
          state_next.shift  = {cap_status, cap_word};
        end
        rusp_pkg::RUSP_ACT_UPDATE:
        begin
          // Only the factory image may write the update register
          if (state_reg.mode == rusp_pkg::RUSP_FACTORY)
            state_next.update = state_reg.shift[CONTROL_W-1:0];
        end
        default:
          state_next.shift = state_reg.shift;
      endcase
    end

    // Watchdog runs only in the application image
    if (state_reg.mode == rusp_pkg::RUSP_APPLICATION)
    begin
      if (state_reg.wd_prev && !watchdog_reload_n)
        state_next.wd_count = wd_initial(state_reg.control);
      else if (watchdog_tick && state_reg.wd_count != '0)
      begin
        state_next.wd_count = state_reg.wd_count - WC_W'(1);
        if (state_reg.wd_count == WC_W'(1))
        begin
          // Timeout falls back to the factory image
          wd_fire               = 1'b1;
          state_next.expired    = 1'b1;
          state_next.start      = 1'b1;
          state_next.to_factory = 1'b1;
          state_next.mode       = rusp_pkg::RUSP_FACTORY;
          state_next.control    = `RUSP_CONTROL_RST;
        end
      end
    end

    // Reconfiguration request from the fabric
    if (clock_enable && state_reg.cfg_prev && !reconfig_request_n)
    begin
      state_next.start      = 1'b1;
      state_next.to_factory =
        (state_reg.mode == rusp_pkg::RUSP_APPLICATION);
    end
    else if (clock_enable && !state_reg.cfg_prev && reconfig_request_n
             && !wd_fire)
    begin
      // A timeout in the same cycle wins, so its expired flag stays set
      // New image comes up under the freshly updated control
      state_next.control  = state_reg.update;
      state_next.mode     = state_reg.to_factory
                            ? rusp_pkg::RUSP_FACTORY
                            : rusp_pkg::RUSP_APPLICATION;
      state_next.expired  = 1'b0;
      state_next.wd_count = wd_initial(state_reg.update);
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg            <= '0;
      state_reg.status     <= `RUSP_STATUS_RST;
      state_reg.control    <= `RUSP_CONTROL_RST;
      state_reg.update     <= `RUSP_UPDATE_RST;
      state_reg.mode       <= rusp_pkg::RUSP_FACTORY;
      state_reg.wd_prev    <= 1'b1;
      state_reg.cfg_prev   <= 1'b1;
    end
    else if (clock_enable)
      state_reg <= state_next;
  end

  // Outputs straight from flip-flops
  assign upgrade_serial_out  = state_reg.shift[SR_W-1];
  assign reconfig_start      = state_reg.start;
  assign reconfig_to_factory = state_reg.to_factory;
  assign running_factory     = (state_reg.mode == rusp_pkg::RUSP_FACTORY);
  assign control_word        = state_reg.control;
  assign watchdog_expired    = state_reg.expired;
endmodule

// ### verif/rusp_props.sv
// Port assertions for the remote upgrade shift port
module rusp_props
#(
  parameter int CONTROL_W = 22
)
(
  input  wire logic                 clock,
  input  wire logic                 clock_enable,
  input  wire logic                 reset_n,
  input  wire logic                 upgrade_shift_clock,
  input  wire logic                 shift_or_load_select,
  input  wire logic                 capture_or_update_select,
  input  wire logic                 upgrade_serial_in,
  input  wire logic                 upgrade_serial_out,
  input  wire logic                 reconfig_request_n,
  input  wire logic                 reconfig_start,
  input  wire logic                 reconfig_to_factory,
  input  wire logic                 running_factory,
  input  wire logic [CONTROL_W-1:0] control_word,
  input  wire logic                 watchdog_expired
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sclk_q;
  logic        rise;
  logic [26:0] hist;
  logic [4:0]  cnt;

  assign rise = clock_enable && upgrade_shift_clock && !sclk_q;

  // Shadow of the last 27 bits shifted in, with a count of shifts since the last capture
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_q <= 1'b0;
      hist   <= 27'h000_0000;
      cnt    <= 5'h00;
    end
    else
    begin
      if (clock_enable)
        sclk_q <= upgrade_shift_clock;
      if (rise && shift_or_load_select)
      begin
        hist <= {hist[25:0], upgrade_serial_in};
        cnt  <= (cnt == 5'h1b) ? cnt : cnt + 5'h01;
      end
      else if (rise && capture_or_update_select)
        cnt <= 5'h00;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_shift_msb: assert property (
    cnt == 5'h1b |-> upgrade_serial_out == hist[26])
    else $error("serial out is not the bit shifted in 27 edges ago");
  a_out_holds: assert property (
    !rise |=> $stable(upgrade_serial_out))
    else $error("serial out moved without a shift clock rise");
  a_start_pulse: assert property (
    clock_enable && $fell(reconfig_request_n) |=> reconfig_start)
    else $error("no start pulse after request");
  a_start_single: assert property (
    reconfig_start |=> !reconfig_start)
    else $error("start pulse longer than one cycle");
  a_to_factory: assert property (
    $fell(reconfig_request_n) && !running_factory |=> reconfig_to_factory)
    else $error("request from application did not target factory");
  a_to_app: assert property (
    $fell(reconfig_request_n) && running_factory |=> !reconfig_to_factory)
    else $error("request from factory did not target application");
  a_mode_follows: assert property (
    clock_enable && $rose(reconfig_request_n)
      |=> running_factory == $past(reconfig_to_factory))
    else $error("running image does not follow the request target");
  a_ctl_quiet: assert property (
    !$rose(reconfig_request_n) |=> $stable(control_word) || watchdog_expired)
    else $error("control word changed without a request release");
endmodule

// ### verif/rusp_user_model.sv
// Fabric user logic that drives the shift port
module rusp_user_model
(
  input  wire logic clock,
  output logic      upgrade_shift_clock,
  output logic      shift_or_load_select,
  output logic      capture_or_update_select,
  output logic      upgrade_serial_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: clock low, selects low
  initial
  begin
    upgrade_shift_clock      = 1'b0;
    shift_or_load_select     = 1'b0;
    capture_or_update_select = 1'b0;
    upgrade_serial_in        = 1'b0;
  end

  // One shift clock period, two cycles high then two low
  task automatic act(input logic s, input logic c, input logic d);
    @(posedge clock);
    shift_or_load_select     <= s;
    capture_or_update_select <= c;
    upgrade_serial_in        <= s ? d : ~upgrade_serial_in;
    upgrade_shift_clock      <= 1'b1;
    repeat (2) @(posedge clock);
    upgrade_shift_clock <= 1'b0;
    @(posedge clock);
  endtask
endmodule

// ### verif/tb.sv
// Self-checking bench of the remote upgrade shift port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [26:0] WR = 27'h6ab_cdef;
  // Two ticks per watchdog step keeps the run short
  localparam int WD_INIT = int'(WR[21:10]) * 2;
  logic        watchdog_reload_n = 1'b1, watchdog_tick = 1'b0;
  logic        clock = 1'b0, reset_n = 1'b0, reconfig_request_n = 1'b1;
  logic        status_valid = 1'b0;
  logic [4:0]  status_data = 5'h00;
  logic        upgrade_shift_clock, shift_or_load_select;
  logic        capture_or_update_select, upgrade_serial_in;
  logic        upgrade_serial_out, status_ready, reconfig_start;
  logic        reconfig_to_factory, running_factory, watchdog_expired;
  logic [21:0] control_word;
  int          errors = 0, comparisons = 0, cycles = 0;

  always #2 clock = ~clock;

  rusp_user_model u_user (.clock(clock),
    .upgrade_shift_clock(upgrade_shift_clock),
    .shift_or_load_select(shift_or_load_select),
    .capture_or_update_select(capture_or_update_select),
    .upgrade_serial_in(upgrade_serial_in));

  rusp_port #(.WD_GRAN(1)) uut (.clock(clock), .clock_enable(1'b1),
    .reset_n(reset_n),
    .upgrade_shift_clock(upgrade_shift_clock),
    .shift_or_load_select(shift_or_load_select),
    .capture_or_update_select(capture_or_update_select),
    .upgrade_serial_in(upgrade_serial_in),
    .upgrade_serial_out(upgrade_serial_out),
    .watchdog_reload_n(watchdog_reload_n),
    .reconfig_request_n(reconfig_request_n), .watchdog_tick(watchdog_tick),
    .status_valid(status_valid), .status_ready(status_ready),
    .status_data(status_data), .reconfig_start(reconfig_start),
    .reconfig_to_factory(reconfig_to_factory),
    .running_factory(running_factory), .control_word(control_word),
    .watchdog_expired(watchdog_expired));

  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [26:0] got, input logic [26:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Capture, read 27 bits while writing 27, then optionally update
  task automatic xfer(input logic [26:0] exp, input logic [26:0] wr,
                      input logic upd);
    logic [26:0] got;
    u_user.act(1'b0, 1'b1, 1'b0);
    for (int i = 26; i >= 0; i--)
    begin
      got = {got[25:0], upgrade_serial_out};
      u_user.act(1'b1, i[0], wr[i]);
    end
    check(got, exp);
    if (upd)
      u_user.act(1'b0, 1'b0, 1'b0);
  endtask

  task automatic push(input logic [4:0] d);
    @(posedge clock);
    status_valid <= 1'b1;
    status_data  <= d;
    @(posedge clock);
    status_valid <= 1'b0;
  endtask

  // Push eight entries to fill the status buffer, check it refuses, then drain by eight captures
  task automatic t_fill();
    for (int i = 0; i < 8; i++)
      push(5'h10 + 5'(i));
    #1;
    check(27'(status_ready), 27'h000_0000);
    for (int i = 0; i < 8; i++)
      u_user.act(1'b0, 1'b1, 1'b0);
    #1;
    check(27'(status_ready), 27'h000_0001);
  endtask

  // Request and release reconfiguration
  task automatic t_reconfig(input logic fac);
    @(posedge clock);
    reconfig_request_n <= 1'b0;
    @(posedge clock);
    #1;
    check({25'h0, reconfig_start, reconfig_to_factory},
          {25'h0, 1'b1, fac});
    @(posedge clock);
    reconfig_request_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check({4'h0, running_factory, control_word}, {4'h0, fac, WR[21:0]});
  endtask

  // Application watchdog: tick, reload, then tick down to the fallback
  task automatic t_watchdog();
    @(posedge clock);
    watchdog_tick <= 1'b1;
    repeat (100) @(posedge clock);
    watchdog_reload_n <= 1'b0;
    @(posedge clock);
    watchdog_reload_n <= 1'b1;
    repeat (WD_INIT - 1) @(posedge clock);
    #1;
    check(27'(watchdog_expired), 27'h000_0000);
    @(posedge clock);
    #1;
    check({23'h00_0000, watchdog_expired, reconfig_start,
           reconfig_to_factory, running_factory}, 27'h000_000f);
    check(27'(control_word), 27'h000_0000);
    @(posedge clock);
    watchdog_tick <= 1'b0;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end

  initial
  begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    push(5'h15);
    xfer({5'h15, 22'h00_0000}, WR, 1'b1);
    xfer({5'h15, WR[21:0]}, 27'h000_0000, 1'b0);
    t_fill();
    t_reconfig(1'b0);
    xfer({5'h17, WR[21:0]}, 27'h000_0000, 1'b1);
    t_reconfig(1'b1);
    t_reconfig(1'b0);
    t_watchdog();
    close_out();
  end
endmodule

bind rusp_port rusp_props #(.CONTROL_W(CONTROL_W)) u_props (.clock(clock),
  .clock_enable(clock_enable), .reset_n(reset_n),
  .upgrade_shift_clock(upgrade_shift_clock),
  .shift_or_load_select(shift_or_load_select),
  .capture_or_update_select(capture_or_update_select),
  .upgrade_serial_in(upgrade_serial_in),
  .upgrade_serial_out(upgrade_serial_out),
  .reconfig_request_n(reconfig_request_n), .reconfig_start(reconfig_start),
  .reconfig_to_factory(reconfig_to_factory),
  .running_factory(running_factory), .control_word(control_word),
  .watchdog_expired(watchdog_expired));
